// ### pkg/dpc_map.vh
// constants for the directional power comparator
`ifndef DPC_MAP_VH
`define DPC_MAP_VH

// angle arithmetic, in calibration steps of 0.05 degree
`define DPC_DEG_TURN 9'h168
`define DPC_STEPS_PER_DEG 14'h0014
`define DPC_FULL_TURN 14'h1c20
`define DPC_QUARTER 14'h0708
`define DPC_HALF 14'h0e10
`define DPC_THREE_QUARTER 14'h1518

// trig table layout
`define DPC_FRAC_BITS 6
`define DPC_TRIG_SHIFT 14
`define DPC_ROM_STEP 5'h01

// quadrant codes
`define DPC_QUAD_0 2'h0
`define DPC_QUAD_1 2'h1
`define DPC_QUAD_2 2'h2
`define DPC_QUAD_3 2'h3

// three-phase power base factor, sized to the threshold path
`define DPC_BASE_MULT 21'h000003

// reset values
`define DPC_RST_OP 21'h000000
`define DPC_RST_CNT 16'h0000
`define DPC_RST_TRIG 16'h0000

`endif

// ### src/dpc_directional_power.v
// two-stage sensitive directional power element
`timescale 1ns/1ps
`include "dpc_map.vh"

// Functional notes
// - stage picks up when P cos(theta) + Q sin(theta) exceeds its threshold
// - theta is the characteristic angle plus the calibration trim
// - calibration trim is counted in steps of 0.05 degree
// - 0/90/180/270 degrees give active/reactive over and underpower
// - thresholds are signed; sign shifts boundary toward operate or restrain
// - thresholds are in three-phase per-unit, base three times V times I
// - both stages drop out while positive-sequence current is below cutoff
// - two stages share the projection, each with own threshold and delay
// - each stage has its own delay from pickup to operate
// - delta VTs use two-wattmeter sum, wye VTs sum all three phases
// - the projected operating quantity is output as a metered value

module dpc_directional_power (
  // clock, reset, enable
  input wire clk_in,
  input wire reset_n_in,
  input wire ce_in,
  // measurement, one processing cycle per strobe
  input wire sample_valid_in,
  input wire signed [15:0] meas_p_a_in,
  input wire signed [15:0] meas_p_b_in,
  input wire signed [15:0] meas_p_c_in,
  input wire signed [15:0] meas_q_a_in,
  input wire signed [15:0] meas_q_b_in,
  input wire signed [15:0] meas_q_c_in,
  input wire [15:0] pos_seq_current_in,
  // settings
  input wire delta_vt_in,
  input wire [8:0] char_angle_in,
  input wire signed [7:0] cal_angle_in,
  input wire [15:0] current_cutoff_in,
  input wire signed [15:0] stage_one_min_power_in,
  input wire signed [15:0] stage_two_min_power_in,
  input wire [15:0] stage_one_delay_in,
  input wire [15:0] stage_two_delay_in,
  // metering
  output reg signed [20:0] op_quantity_out,
  output reg op_valid_out,
  // stage outputs
  output wire stage_one_pickup_out,
  output wire stage_two_pickup_out,
  output wire stage_one_operate_out,
  output wire stage_two_operate_out
);

  wire [8:0] char_mod;
  wire [13:0] char_units;
  wire [13:0] ang_raw;
  reg [13:0] ang_fix;
  reg [13:0] rem_w;
  reg [1:0] quad;
  wire [13:0] bwd_w;
  wire [10:0] u_fwd;
  wire [10:0] u_bwd;
  wire signed [15:0] f_lo;
  wire signed [15:0] f_hi;
  wire signed [15:0] b_lo;
  wire signed [15:0] b_hi;
  wire signed [17:0] p_sum;
  wire signed [17:0] q_sum;

  reg v_s1_reg;
  reg v_s2_reg;
  reg v_s3_reg;
  reg cut_s1_reg;
  reg cut_s2_reg;
  reg cut_s3_reg;
  reg signed [17:0] p_s1_reg;
  reg signed [17:0] q_s1_reg;
  reg signed [17:0] p_s2_reg;
  reg signed [17:0] q_s2_reg;
  reg [1:0] quad_s1_reg;
  reg [5:0] frf_s1_reg;
  reg [5:0] frb_s1_reg;
  reg signed [15:0] sin_s2_reg;
  reg signed [15:0] cos_s2_reg;

  reg signed [23:0] prod_f;
  reg signed [23:0] prod_b;
  reg [15:0] s_fwd;
  reg [15:0] s_bwd;
  reg signed [15:0] sin_next;
  reg signed [15:0] cos_next;
  reg signed [34:0] proj;

  // angle sum in 0.05 degree steps, wrapped to one turn
  assign char_mod = (char_angle_in >= `DPC_DEG_TURN) ? char_angle_in - `DPC_DEG_TURN :
    char_angle_in;
  assign char_units = char_mod * `DPC_STEPS_PER_DEG;
  assign ang_raw = char_units + {{6{cal_angle_in[7]}}, cal_angle_in};

  always @*
  begin
    ang_fix = ang_raw;
    if (ang_raw[13])
      ang_fix = ang_raw + `DPC_FULL_TURN;
    else if (ang_raw >= `DPC_FULL_TURN)
      ang_fix = ang_raw - `DPC_FULL_TURN;
  end

  // fold into quadrant and offset; handles any direction
  always @*
  begin
    quad = `DPC_QUAD_0;
    rem_w = ang_fix;
    if (ang_fix >= `DPC_THREE_QUARTER)
    begin
      quad = `DPC_QUAD_3;
      rem_w = ang_fix - `DPC_THREE_QUARTER;
    end
    else if (ang_fix >= `DPC_HALF)
    begin
      quad = `DPC_QUAD_2;
      rem_w = ang_fix - `DPC_HALF;
    end
    else if (ang_fix >= `DPC_QUARTER)
    begin
      quad = `DPC_QUAD_1;
      rem_w = ang_fix - `DPC_QUARTER;
    end
  end

  assign bwd_w = `DPC_QUARTER - rem_w;
  assign u_fwd = rem_w[10:0];
  assign u_bwd = bwd_w[10:0];

  dpc_trig_rom u_rom_fwd (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .addr_lo_in(u_fwd[10:6]),
    .addr_hi_in(u_fwd[10:6] + `DPC_ROM_STEP),
    .data_lo_out(f_lo),
    .data_hi_out(f_hi)
  );

  dpc_trig_rom u_rom_bwd (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .addr_lo_in(u_bwd[10:6]),
    .addr_hi_in(u_bwd[10:6] + `DPC_ROM_STEP),
    .data_lo_out(b_lo),
    .data_hi_out(b_hi)
  );

  // three-phase power: delta uses the two wattmeters on a and c
  assign p_sum = delta_vt_in ? meas_p_a_in + meas_p_c_in :
    meas_p_a_in + meas_p_b_in + meas_p_c_in;
  assign q_sum = delta_vt_in ? meas_q_a_in + meas_q_c_in :
    meas_q_a_in + meas_q_b_in + meas_q_c_in;

  // linear interpolation between table points, quadrant signs
  always @*
  begin
    prod_f = $signed({f_hi[15], f_hi} - {f_lo[15], f_lo}) * $signed({1'b0, frf_s1_reg});
    prod_b = $signed({b_hi[15], b_hi} - {b_lo[15], b_lo}) * $signed({1'b0, frb_s1_reg});
    s_fwd = f_lo + prod_f[21:6];
    s_bwd = b_lo + prod_b[21:6];
    case (quad_s1_reg)
      `DPC_QUAD_0:
      begin
        sin_next = s_fwd;
        cos_next = s_bwd;
      end
      `DPC_QUAD_1:
      begin
        sin_next = s_bwd;
        cos_next = -s_fwd;
      end
      `DPC_QUAD_2:
      begin
        sin_next = -s_fwd;
        cos_next = -s_bwd;
      end
      default:
      begin
        sin_next = -s_bwd;
        cos_next = s_fwd;
      end
    endcase
    proj = p_s2_reg * cos_s2_reg + q_s2_reg * sin_s2_reg;
  end

  // three-stage pipeline per sample strobe
  always @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      v_s1_reg <= 1'b0;
      v_s2_reg <= 1'b0;
      v_s3_reg <= 1'b0;
      cut_s1_reg <= 1'b0;
      cut_s2_reg <= 1'b0;
      cut_s3_reg <= 1'b0;
      p_s1_reg <= 18'h00000;
      q_s1_reg <= 18'h00000;
      p_s2_reg <= 18'h00000;
      q_s2_reg <= 18'h00000;
      quad_s1_reg <= `DPC_QUAD_0;
      frf_s1_reg <= 6'h00;
      frb_s1_reg <= 6'h00;
      sin_s2_reg <= `DPC_RST_TRIG;
      cos_s2_reg <= `DPC_RST_TRIG;
      op_quantity_out <= `DPC_RST_OP;
      op_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      v_s1_reg <= sample_valid_in;
      v_s2_reg <= v_s1_reg;
      v_s3_reg <= v_s2_reg;
      op_valid_out <= v_s2_reg;
      cut_s1_reg <= pos_seq_current_in >= current_cutoff_in;
      cut_s2_reg <= cut_s1_reg;
      cut_s3_reg <= cut_s2_reg;
      if (sample_valid_in)
      begin
        p_s1_reg <= p_sum;
        q_s1_reg <= q_sum;
        quad_s1_reg <= quad;
        frf_s1_reg <= u_fwd[5:0];
        frb_s1_reg <= u_bwd[5:0];
      end
      if (v_s1_reg)
      begin
        p_s2_reg <= p_s1_reg;
        q_s2_reg <= q_s1_reg;
        sin_s2_reg <= sin_next;
        cos_s2_reg <= cos_next;
      end
      if (v_s2_reg)
        op_quantity_out <= proj[34:14];
    end
  end

  // per-stage compare and definite delay
  wire signed [31:0] thr_bus;
  wire [31:0] dly_bus;
  wire [1:0] pick_bus;
  wire [1:0] oper_bus;
  assign thr_bus = {stage_two_min_power_in, stage_one_min_power_in};
  assign dly_bus = {stage_two_delay_in, stage_one_delay_in};

  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_stage
      wire signed [15:0] thr;
      wire signed [20:0] thr3;
      wire cond;
      reg [15:0] cnt_reg;
      reg pick_reg;
      reg oper_reg;
      assign thr = thr_bus[16*k+15:16*k];
      // phase-base projection vs three-phase threshold
      assign thr3 = {{5{thr[15]}}, thr} * `DPC_BASE_MULT;
      assign cond = cut_s3_reg && (op_quantity_out > thr3);
      always @(posedge clk_in)
      begin
        if (!reset_n_in)
        begin
          cnt_reg <= `DPC_RST_CNT;
          pick_reg <= 1'b0;
          oper_reg <= 1'b0;
        end
        else if (ce_in && v_s3_reg)
        begin
          if (!cond)
          begin
            cnt_reg <= `DPC_RST_CNT;
            pick_reg <= 1'b0;
            oper_reg <= 1'b0;
          end
          else
          begin
            pick_reg <= 1'b1;
            if (cnt_reg >= dly_bus[16*k+15:16*k])
              oper_reg <= 1'b1;
            else
              cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end
      assign pick_bus[k] = pick_reg;
      assign oper_bus[k] = oper_reg;
    end
  endgenerate

  assign stage_one_pickup_out = pick_bus[0];
  assign stage_two_pickup_out = pick_bus[1];
  assign stage_one_operate_out = oper_bus[0];
  assign stage_two_operate_out = oper_bus[1];

endmodule

// ### src/dpc_trig_rom.v
// quarter-wave sine table, two registered read ports
`timescale 1ns/1ps
`include "dpc_map.vh"

module dpc_trig_rom (
  // clock, reset, enable
  input wire clk_in,
  input wire reset_n_in,
  input wire ce_in,
  // read addresses
  input wire [4:0] addr_lo_in,
  input wire [4:0] addr_hi_in,
  // read data, sine scaled by 2^14
  output reg signed [15:0] data_lo_out,
  output reg signed [15:0] data_hi_out
);

  // sine at index times 3.2 degrees; entry 1d repeats the peak
  // since it only bounds the last 0.4 degree before 90, keeping 90 exact
  function [15:0] sine_at;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: sine_at = 16'h0000;
        5'h01: sine_at = 16'h0393;
        5'h02: sine_at = 16'h0722;
        5'h03: sine_at = 16'h0aac;
        5'h04: sine_at = 16'h0e2e;
        5'h05: sine_at = 16'h11a4;
        5'h06: sine_at = 16'h150c;
        5'h07: sine_at = 16'h1863;
        5'h08: sine_at = 16'h1ba7;
        5'h09: sine_at = 16'h1ed5;
        5'h0a: sine_at = 16'h21ea;
        5'h0b: sine_at = 16'h24e4;
        5'h0c: sine_at = 16'h27c1;
        5'h0d: sine_at = 16'h2a7e;
        5'h0e: sine_at = 16'h2d19;
        5'h0f: sine_at = 16'h2f90;
        5'h10: sine_at = 16'h31e1;
        5'h11: sine_at = 16'h340a;
        5'h12: sine_at = 16'h3609;
        5'h13: sine_at = 16'h37de;
        5'h14: sine_at = 16'h3986;
        5'h15: sine_at = 16'h3b00;
        5'h16: sine_at = 16'h3c4b;
        5'h17: sine_at = 16'h3d65;
        5'h18: sine_at = 16'h3e4f;
        5'h19: sine_at = 16'h3f07;
        5'h1a: sine_at = 16'h3f8d;
        5'h1b: sine_at = 16'h3fe0;
        5'h1c: sine_at = 16'h4000;
        5'h1d: sine_at = 16'h4000;
        default: sine_at = 16'h4000;
      endcase
    end
  endfunction

  always @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      data_lo_out <= `DPC_RST_TRIG;
      data_hi_out <= `DPC_RST_TRIG;
    end
    else if (ce_in)
    begin
      data_lo_out <= sine_at(addr_lo_in);
      data_hi_out <= sine_at(addr_hi_in);
    end
  end

endmodule

// ### verification/dpc_directional_power_assertions.sv
// port assertions for the comparator
`timescale 1ns/1ps
module dpc_dp_chk (
  // clock and inputs
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sample_valid_in,
  input wire logic [15:0] pos_seq_current_in,
  input wire logic [15:0] current_cutoff_in,
  input wire logic [15:0] stage_one_delay_in,
  input wire logic [15:0] stage_two_delay_in,
  // outputs
  input wire logic signed [20:0] op_quantity_out,
  input wire logic op_valid_out,
  input wire logic stage_one_pickup_out,
  input wire logic stage_two_pickup_out,
  input wire logic stage_one_operate_out,
  input wire logic stage_two_operate_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_take;
    sample_valid_in;
  endsequence
  sequence s_low;
    sample_valid_in && pos_seq_current_in < current_cutoff_in;
  endsequence
  property p_lat;
    s_take |-> ##3 op_valid_out;
  endproperty
  a_lat: assert property (p_lat) else $error("no result after strobe");
  property p_sup;
    s_low |-> ##4 !(stage_one_pickup_out || stage_two_pickup_out);
  endproperty
  a_sup: assert property (p_sup) else $error("stage up without current");
  property p_op1;
    stage_one_operate_out |-> stage_one_pickup_out;
  endproperty
  a_op1: assert property (p_op1) else $error("stage one operate alone");
  property p_op2;
    stage_two_operate_out |-> stage_two_pickup_out;
  endproperty
  a_op2: assert property (p_op2) else $error("stage two operate alone");
  property p_d0;
    stage_two_delay_in == 0 && stage_two_pickup_out |-> stage_two_operate_out;
  endproperty
  a_d0: assert property (p_d0) else $error("zero delay not immediate");
  property p_d1;
    stage_one_delay_in != 0 && $rose(stage_one_pickup_out) |-> !stage_one_operate_out;
  endproperty
  a_d1: assert property (p_d1) else $error("stage one delay skipped");
  property p_hold;
    $rose(stage_one_operate_out) && stage_one_delay_in != 0 |-> $past(stage_one_pickup_out);
  endproperty
  a_hold: assert property (p_hold) else $error("operate without held pickup");
  property p_vq;
    !$stable(op_quantity_out) |-> op_valid_out;
  endproperty
  a_vq: assert property (p_vq) else $error("quantity moved without valid");
  property p_pk;
    !$stable(stage_one_pickup_out) || !$stable(stage_two_pickup_out) |-> $past(op_valid_out);
  endproperty
  a_pk: assert property (p_pk) else $error("pickup moved off evaluation");
endmodule
bind dpc_directional_power dpc_dp_chk u_chk (.*);

// ### verification/dpc_directional_power_tb_top.sv
// self-checking bench for the directional power comparator
`timescale 1ns/1ps
module dpc_directional_power_tb_top;
  reg clk_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg go = 1'b0;
  reg dvt = 1'b0;
  reg [8:0] ang = 9'h000;
  reg signed [7:0] cal = 8'h00;
  // stage one slow alarm, stage two fast trip
  reg signed [15:0] t1 = 16'h0014;
  reg signed [15:0] t2 = 16'hffe2;
  reg [15:0] d1 = 16'h0002;
  reg [15:0] d2 = 16'h0000;
  reg [111:0] mv = 112'h0;
  reg [24:0] n = 25'h0;
  reg [3:0] pend = 4'h0;
  reg hp = 1'b0;
  reg [24:0] nq[$];
  wire [111:0] m;
  wire sv, ov, p1, p2, o1, o2;
  wire signed [20:0] q;
  integer err_count = 0;
  integer samples_checked = 0;
  integer seed = 32'h93d1d81a;
  integer r1 = 0;
  integer r2 = 0;
  integer cyc = 0;
  integer i, k;
  integer at[0:6] = '{0, 90, 180, 270, 450, 89, 91};
  integer ct[0:6] = '{0, 0, 0, 0, 0, 20, -20};
  always #2.5 clk_in = ~clk_in;
  dpc_meas_source u_src (.clk_in(clk_in), .go_in(go), .meas_in(mv), .meas_out(m),
    .valid_out(sv));
  dpc_directional_power DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
    .sample_valid_in(sv), .meas_p_a_in(m[111:96]), .meas_p_b_in(m[95:80]),
    .meas_p_c_in(m[79:64]), .meas_q_a_in(m[63:48]), .meas_q_b_in(m[47:32]),
    .meas_q_c_in(m[31:16]), .pos_seq_current_in(m[15:0]), .delta_vt_in(dvt),
    .char_angle_in(ang), .cal_angle_in(cal), .current_cutoff_in(16'h0064),
    .stage_one_min_power_in(t1), .stage_two_min_power_in(t2),
    .stage_one_delay_in(d1), .stage_two_delay_in(d2), .op_quantity_out(q),
    .op_valid_out(ov), .stage_one_pickup_out(p1), .stage_two_pickup_out(p2),
    .stage_one_operate_out(o1), .stage_two_operate_out(o2));
  task stop_test;
    begin
      chk("queue", 21'h000000, nq.size());
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [20:0] e, input [20:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (e !== s)
      begin
        $display("BAD %s exp %0d seen %0d", nm, e, s);
        err_count = err_count + 1;
      end
    end
  endtask
  task smp(input integer pa, pb, pc, qa, qb, qc, c);
    integer p, x, e, a;
    reg c1, c2;
    begin
      p = dvt ? pa + pc : pa + pb + pc;
      x = dvt ? qa + qc : qa + qb + qc;
      a = ang % 360;
      a = (a * 20 + cal) / 1800;
      e = a == 0 ? p : a == 1 ? x : a == 2 ? -p : -x;
      c1 = c >= 100 && e > 3 * t1;
      c2 = c >= 100 && e > 3 * t2;
      r1 = c1 ? r1 + 1 : 0;
      r2 = c2 ? r2 + 1 : 0;
      nq.push_back({e[20:0], c1, c2, c1 && r1 > d1, c2 && r2 > d2});
      mv <= {pa[15:0], pb[15:0], pc[15:0], qa[15:0], qb[15:0], qc[15:0], c[15:0]};
      go <= 1'b1;
      @(negedge clk_in);
    end
  endtask
  task idl;
    begin
      go <= 1'b0;
      repeat (8) @(negedge clk_in);
    end
  endtask
  // checks each result against the oldest note
  always @(negedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
    else
    begin
      if (hp)
        chk("stage", pend, {p1, p2, o1, o2});
      hp = 1'b0;
      if (ov === 1'b1)
      begin
        n = nq.pop_front();
        chk("opq", n[24:4], q);
        pend = n[3:0];
        hp = 1'b1;
      end
    end
  end
  initial
  begin
    repeat (5) @(negedge clk_in);
    reset_n_in = 1'b1;
    for (i = 0; i < 14; i = i + 1)
    begin
      idl;
      dvt = i % 2;
      ang = at[i / 2];
      cal = ct[i / 2];
      for (k = 0; k < 8; k = k + 1)
        smp($random(seed) % 300, $random(seed) % 300, $random(seed) % 300,
          $random(seed) % 300, $random(seed) % 300, $random(seed) % 300,
          {$random(seed)} % 400);
    end
    idl;
    $display("test angle sweep done");
    dvt = 1'b0;
    ang = 9'h000;
    cal = 8'h00;
    smp(-100, 0, 0, 0, 0, 0, 400);
    for (k = 0; k < 4; k = k + 1)
      smp(100, 100, k, 0, 0, 0, 100);
    smp(100, 100, 0, 0, 0, 0, 99);
    smp(100, 100, 0, 0, 0, 0, 400);
    smp(20, 20, 20, 0, 0, 0, 400);
    smp(-80, 0, 0, 0, 0, 0, 400);
    idl;
    $display("test stage timing done");
    stop_test;
  end
endmodule

// ### verification/dpc_meas_source.sv
// measurement channel model feeding the comparator
`timescale 1ns/1ps
module dpc_meas_source (
  // clock and request
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [111:0] meas_in,
  // channel outputs
  output logic [111:0] meas_out,
  output logic valid_out
);
  initial meas_out = 112'h0;
  initial valid_out = 1'b0;
  always @(negedge clk_in)
  begin
    valid_out <= go_in;
    // data not held outside a strobe
    meas_out <= go_in ? meas_in : ~meas_out;
  end
endmodule
